// ### hdl/awc_adc_window_compare.sv
/*
 * Converter control with window comparator, tracking configuration and
 * a zero-wait APB register slave with a level interrupt.
 * Assumes the analog converter runs on pclk, pulses conv_done with
 * conv_data valid, and timer overflow inputs are one-cycle pulses on pclk.
 */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module awc_adc_window_compare
	import awc_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic conv_done,
	input wire logic [AWC_DATA_W-1:0] conv_data,
	input wire logic timer2_overflow,
	input wire logic timer3_overflow,
	input wire logic ext_convert_strobe,
	output logic conv_start,
	output logic converter_enable,
	output logic burst_mode_enable,
	output logic left_justify_select,
	output logic [1:0] track_mode_select,
	output logic [1:0] post_track_time_select,
	output logic [3:0] burst_powerup_time,
	output logic window_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	// Register images and their next values
	logic [7:0] adc_tracking_config_reg;
	logic [7:0] adc_tracking_config_next;
	logic [7:0] converter_control_reg;
	logic [7:0] converter_control_next;
	logic [7:0] lower_limit_high_byte_reg;
	logic [7:0] lower_limit_high_byte_next;
	logic [7:0] lower_limit_low_byte_reg;
	logic [7:0] lower_limit_low_byte_next;
	logic [7:0] upper_limit_high_byte_reg;
	logic [7:0] upper_limit_high_byte_next;
	logic [7:0] upper_limit_low_byte_reg;
	logic [7:0] upper_limit_low_byte_next;
	logic [AWC_WORD_W-1:0] result_reg;
	logic [AWC_WORD_W-1:0] result_next;
	logic [1:0] int_status_reg;
	logic [1:0] int_status_next;
	logic [1:0] int_enable_reg;
	logic [1:0] int_enable_next;
	logic irq_reg;
	logic irq_next;
	logic conv_start_reg;
	logic conv_start_next;
	logic strobe_last_reg;
	logic strobe_last_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;

	// Decode and datapath nets
	logic strobe_sync;
	logic [AWC_IDX_W-1:0] idx;
	logic wr_en;
	logic mapped;
	logic [7:0] rd_byte;
	logic [AWC_WORD_W-1:0] new_word;
	logic [AWC_WORD_W-1:0] gt_word;
	logic [AWC_WORD_W-1:0] lt_word;
	logic new_match;
	logic sw_start;
	logic trigger;
	logic [1:0] start_sel;
	logic [1:0] int_set;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Byte lanes are ignored; every register is one aligned word
	assign idx = paddr[AWC_IDX_W+1:2];
	// Write lands only on the access edge that carries pready
	// A write taken in setup alone would land before the slave answered
	assign wr_en = psel && penable && pwrite && pready_reg;

	// Read mux and map check, based on the address held from setup
	// The clear register reads zero so a read-modify-write clears nothing
	always_comb begin
		mapped = 1'b1;
		rd_byte = 8'h00;
		unique case (idx)
			AWC_IDX_TRACK: rd_byte = adc_tracking_config_reg;
			AWC_IDX_CTRL: rd_byte = converter_control_reg;
			AWC_IDX_RES_L: rd_byte = result_reg[7:0];
			AWC_IDX_RES_H: rd_byte = result_reg[15:8];
			AWC_IDX_GT_L: rd_byte = lower_limit_low_byte_reg;
			AWC_IDX_GT_H: rd_byte = lower_limit_high_byte_reg;
			AWC_IDX_LT_L: rd_byte = upper_limit_low_byte_reg;
			AWC_IDX_LT_H: rd_byte = upper_limit_high_byte_reg;
			AWC_IDX_INT_STAT: rd_byte = {6'h00, int_status_reg};
			AWC_IDX_INT_CLR: rd_byte = 8'h00;
			AWC_IDX_INT_EN: rd_byte = {6'h00, int_enable_reg};
			default: mapped = 1'b0;
		endcase
	end

	// Zero wait states: answer is prepared during setup
	// Trade-off: decode must settle within the setup cycle
	always_comb begin
		pready_next = psel && !penable;
		pslverr_next = psel && !penable && !mapped;
		prdata_next = prdata_reg;
		if (psel && !penable) begin
			prdata_next = {24'h000000, rd_byte};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion start

	// The strobe pin is asynchronous; two flops guard against metastability
	awc_sync u_strobe_sync (
		.clk(pclk),
		.rst_n(presetn),
		.async_in(ext_convert_strobe),
		.sync_out(strobe_sync)
	);

	// Software start is a busy write whose written select is also 00
	assign start_sel = converter_control_reg[AWC_CN_START_LO+:2];
	assign sw_start = wr_en && (idx == AWC_IDX_CTRL) && pwdata[AWC_CN_BUSY];

	// Start source select; nothing starts while the converter is off
	always_comb begin
		strobe_last_next = strobe_sync;
		trigger = 1'b0;
		unique case (start_sel)
			AWC_START_SW: trigger = sw_start && (pwdata[1:0] == AWC_START_SW);
			AWC_START_TIMER3: trigger = timer3_overflow;
			// [R9] strobe rising edge
			AWC_START_EXT: trigger = strobe_sync && !strobe_last_reg;
			// [R10] timer 2 overflow
			AWC_START_TIMER2: trigger = timer2_overflow;
		endcase
		conv_start_next = trigger && converter_control_reg[AWC_CN_ENABLE];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result and window check

	// Limits are not justified; software programs them as full words
	// [R8] justify result, limits unchanged
	assign new_word = converter_control_reg[AWC_CN_LJUST] ?
		{conv_data, 4'h0} : {4'h0, conv_data};
	// [R3] limit pairs form words
	assign gt_word = {lower_limit_high_byte_reg, lower_limit_low_byte_reg};
	assign lt_word = {upper_limit_high_byte_reg, upper_limit_low_byte_reg};

	// [R1] every result is compared
	awc_window_cmp #(
		.WORD_W(AWC_WORD_W)
	) u_window_cmp (
		.result_word(new_word),
		.gt_limit(gt_word),
		.lt_limit(lt_word),
		.match(new_match)
	);

	// Result keeps its justification so software reads what was compared
	assign result_next = conv_done ? new_word : result_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and hardware flags

	// Software writes first, hardware sets after, so a set beats a clear
	// Writes to the result and status images are ignored without an error
	always_comb begin
		adc_tracking_config_next = adc_tracking_config_reg;
		converter_control_next = converter_control_reg;
		lower_limit_high_byte_next = lower_limit_high_byte_reg;
		lower_limit_low_byte_next = lower_limit_low_byte_reg;
		upper_limit_high_byte_next = upper_limit_high_byte_reg;
		upper_limit_low_byte_next = upper_limit_low_byte_reg;
		int_enable_next = int_enable_reg;
		int_status_next = int_status_reg;
		if (wr_en) begin
			unique case (idx)
				// [R11] track field writable
				AWC_IDX_TRACK: adc_tracking_config_next = pwdata[7:0];
				AWC_IDX_CTRL: begin
					converter_control_next[AWC_CN_ENABLE] = pwdata[AWC_CN_ENABLE];
					converter_control_next[AWC_CN_BURST] = pwdata[AWC_CN_BURST];
					converter_control_next[AWC_CN_LJUST] = pwdata[AWC_CN_LJUST];
					converter_control_next[1:0] = pwdata[1:0];
					// Flags only clear by writing zero
					converter_control_next[AWC_CN_DONE] =
						converter_control_reg[AWC_CN_DONE] & pwdata[AWC_CN_DONE];
					converter_control_next[AWC_CN_WINDOW] =
						converter_control_reg[AWC_CN_WINDOW] & pwdata[AWC_CN_WINDOW];
				end
				// [R3] limit bytes writable
				AWC_IDX_GT_L: lower_limit_low_byte_next = pwdata[7:0];
				AWC_IDX_GT_H: lower_limit_high_byte_next = pwdata[7:0];
				AWC_IDX_LT_L: upper_limit_low_byte_next = pwdata[7:0];
				AWC_IDX_LT_H: upper_limit_high_byte_next = pwdata[7:0];
				AWC_IDX_INT_CLR: int_status_next = int_status_reg & ~pwdata[1:0];
				AWC_IDX_INT_EN: int_enable_next = pwdata[1:0];
				default: ;
			endcase
		end
		// Busy follows the converter
		// A start and a done in one cycle leave busy low, done coming later
		if (conv_start_reg) begin
			converter_control_next[AWC_CN_BUSY] = 1'b1;
		end
		if (conv_done) begin
			converter_control_next[AWC_CN_BUSY] = 1'b0;
			converter_control_next[AWC_CN_DONE] = 1'b1;
		end
		// [R2] match sets the flag
		if (conv_done && new_match) begin
			converter_control_next[AWC_CN_WINDOW] = 1'b1;
		end
		int_status_next = int_status_next | int_set;
	end

	// Both events also raise sticky status bits for the interrupt line
	assign int_set[AWC_INT_WINDOW] = conv_done && new_match;
	assign int_set[AWC_INT_DONE] = conv_done;

	// [R2] flag drives the interrupt
	// Built from next values so the line moves with the status edge
	assign irq_next = |(int_status_next & int_enable_next);

	////////////////////////////////////////////////////////////////////////////////
	// State registers

	// Reset branch assigns constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_tracking_config_reg <= AWC_TRACK_RST;
			converter_control_reg <= AWC_CTRL_RST;
			lower_limit_high_byte_reg <= AWC_GT_RST;
			lower_limit_low_byte_reg <= AWC_GT_RST;
			upper_limit_high_byte_reg <= AWC_LT_RST;
			upper_limit_low_byte_reg <= AWC_LT_RST;
			result_reg <= 16'h0000;
			int_status_reg <= AWC_INT_RST;
			int_enable_reg <= AWC_INT_RST;
			irq_reg <= 1'b0;
			conv_start_reg <= 1'b0;
			strobe_last_reg <= 1'b0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			adc_tracking_config_reg <= adc_tracking_config_next;
			converter_control_reg <= converter_control_next;
			lower_limit_high_byte_reg <= lower_limit_high_byte_next;
			lower_limit_low_byte_reg <= lower_limit_low_byte_next;
			upper_limit_high_byte_reg <= upper_limit_high_byte_next;
			upper_limit_low_byte_reg <= upper_limit_low_byte_next;
			result_reg <= result_next;
			int_status_reg <= int_status_next;
			int_enable_reg <= int_enable_next;
			irq_reg <= irq_next;
			conv_start_reg <= conv_start_next;
			strobe_last_reg <= strobe_last_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flops

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign conv_start = conv_start_reg;
	assign converter_enable = converter_control_reg[AWC_CN_ENABLE];
	assign burst_mode_enable = converter_control_reg[AWC_CN_BURST];
	assign left_justify_select = converter_control_reg[AWC_CN_LJUST];
	// [R11] track mode to analog
	assign track_mode_select = adc_tracking_config_reg[AWC_TK_MODE_LO+:2];
	// Limitation: tracking fields go out raw, the reserved code included
	assign post_track_time_select = adc_tracking_config_reg[AWC_TK_POST_LO+:2];
	assign burst_powerup_time = adc_tracking_config_reg[AWC_TK_PWR_LO+:4];
	assign window_irq = irq_reg;

endmodule : awc_adc_window_compare

// ### pkg/awc_pkg.sv
/*
 * Constants for the converter window-compare control block: register
 * indices, field positions, reset values and code points.
 * Assumes an APB master with 32-bit data; byte address = index * 4.
 */
// Operation
// [R1] Every finished conversion word is checked against both limits with no software step.
// [R2] A window match sets a flag in the converter control register, usable polled or as interrupt.
// [R3] Two writable limit pairs, greater-than and less-than, each a high and a low byte.
// [R4] Inside or outside operation follows only from which limit is larger, with no mode bit.
// [R5] Results are 12-bit unsigned values and are compared as unsigned.
// [R6] Inside: flag only when greater-than limit < result < less-than limit, strictly.
// [R7] Outside: flag only when result < less-than limit or result > greater-than limit, strictly.
// [R8] Left-justified results are compared with the same limit values as right-justified ones.
// [R9] Start select 10 starts a conversion on each rising edge of the external strobe.
// [R10] Start select 11 starts a conversion on each timer 2 overflow.
// [R11] Track mode field: 00 reserved, 01 post, 10 pre, 11 dual, dual after reset.
package awc_pkg;

	localparam int AWC_DATA_W = 12;
	localparam int AWC_WORD_W = 16;
	localparam int AWC_IDX_W = 10;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices
	localparam logic [9:0] AWC_IDX_TRACK = 10'h0ba;
	localparam logic [9:0] AWC_IDX_CTRL = 10'h0e8;
	localparam logic [9:0] AWC_IDX_RES_L = 10'h0bd;
	localparam logic [9:0] AWC_IDX_RES_H = 10'h0be;
	localparam logic [9:0] AWC_IDX_GT_L = 10'h0c3;
	localparam logic [9:0] AWC_IDX_GT_H = 10'h0c4;
	localparam logic [9:0] AWC_IDX_LT_L = 10'h0c5;
	localparam logic [9:0] AWC_IDX_LT_H = 10'h0c6;
	localparam logic [9:0] AWC_IDX_INT_STAT = 10'h0f0;
	localparam logic [9:0] AWC_IDX_INT_CLR = 10'h0f1;
	localparam logic [9:0] AWC_IDX_INT_EN = 10'h0f2;

	////////////////////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int AWC_CN_ENABLE = 7;
	localparam int AWC_CN_BURST = 6;
	localparam int AWC_CN_DONE = 5;
	localparam int AWC_CN_BUSY = 4;
	localparam int AWC_CN_WINDOW = 3;
	localparam int AWC_CN_LJUST = 2;
	localparam int AWC_CN_START_LO = 0;

	// Tracking register fields
	localparam int AWC_TK_PWR_LO = 4;
	localparam int AWC_TK_MODE_LO = 2;
	localparam int AWC_TK_POST_LO = 0;

	// Interrupt status bits
	localparam int AWC_INT_WINDOW = 0;
	localparam int AWC_INT_DONE = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] AWC_TRACK_RST = 8'hff;
	localparam logic [7:0] AWC_CTRL_RST = 8'h00;
	localparam logic [7:0] AWC_GT_RST = 8'hff;
	localparam logic [7:0] AWC_LT_RST = 8'h00;
	localparam logic [1:0] AWC_INT_RST = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Start select codes
	localparam logic [1:0] AWC_START_SW = 2'h0;
	localparam logic [1:0] AWC_START_TIMER3 = 2'h1;
	localparam logic [1:0] AWC_START_EXT = 2'h2;
	localparam logic [1:0] AWC_START_TIMER2 = 2'h3;

	// Track mode codes
	localparam logic [1:0] AWC_TRACK_RSVD = 2'h0;
	localparam logic [1:0] AWC_TRACK_POST = 2'h1;
	localparam logic [1:0] AWC_TRACK_PRE = 2'h2;
	localparam logic [1:0] AWC_TRACK_DUAL = 2'h3;

endpackage : awc_pkg

// ### hdl/awc_sync.sv
/*
 * Two-stage synchroniser for a single level from outside the clock domain.
 * Assumes the input is a slow pin level, not a data bus.
 */
`timescale 1ns/1ps
module awc_sync
	import awc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);

	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;

	// First stage feeds only the second one
	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;

endmodule : awc_sync

// ### hdl/awc_window_cmp.sv
/*
 * Combinational window comparator on one result word and two limits.
 * Assumes all three words share the same justification.
 */
`timescale 1ns/1ps
module awc_window_cmp
	import awc_pkg::*;
#(
	parameter int WORD_W = AWC_WORD_W
)
(
	input wire logic [WORD_W-1:0] result_word,
	input wire logic [WORD_W-1:0] gt_limit,
	input wire logic [WORD_W-1:0] lt_limit,
	output logic match
);

	logic above_gt;
	logic below_lt;

	// [R5] unsigned strict compares
	assign above_gt = result_word > gt_limit;
	assign below_lt = result_word < lt_limit;

	// Limit order picks inside or outside; equal limits act as outside
	always_comb begin
		// [R4] order decides mode
		if (lt_limit > gt_limit) begin
			// [R6] inside window
			match = above_gt && below_lt;
		end else begin
			// [R7] outside window
			match = above_gt || below_lt;
		end
	end

endmodule : awc_window_cmp

// ### test/awc_adc_window_compare_chk.sv
/*
 * Port checker for the window-compare block, bound to its top module.
 * Assumes the zero-wait register bus and registered outputs.
 */
`timescale 1ns/1ps
module awc_adc_window_compare_chk
	import awc_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic conv_done,
	input wire logic conv_start,
	input wire logic converter_enable,
	input wire logic burst_mode_enable,
	input wire logic left_justify_select,
	input wire logic [1:0] track_mode_select,
	input wire logic [1:0] post_track_time_select,
	input wire logic [3:0] burst_powerup_time,
	input wire logic window_irq
);
	logic wr_acc;
	logic trk_acc;
	logic ctl_acc;

	// Write strobes decoded from the bus; outputs may only move after one
	assign wr_acc = psel && penable && pwrite;
	assign trk_acc = wr_acc && (paddr[ADDR_W-1:2] == AWC_IDX_TRACK);
	assign ctl_acc = wr_acc && (paddr[ADDR_W-1:2] == AWC_IDX_CTRL);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////////
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	chk_track_mapped: assert property (pready && paddr[ADDR_W-1:2] == AWC_IDX_TRACK |-> !pslverr)
		else $error("tracking register refused");
	chk_track_write: assert property ($changed({track_mode_select,
		post_track_time_select, burst_powerup_time}) |-> $past(trk_acc) || $past(trk_acc, 2))
		else $error("tracking outputs moved without write");
	chk_ctrl_write: assert property ($changed({converter_enable, burst_mode_enable,
		left_justify_select}) |-> $past(ctl_acc) || $past(ctl_acc, 2))
		else $error("control outputs moved without write");
	chk_start_enabled: assert property (conv_start |-> $past(converter_enable))
		else $error("start while converter disabled");
	chk_irq_rise: assert property ($rose(window_irq) |-> $past(conv_done) ||
		$past(conv_done, 2) || $past(wr_acc) || $past(wr_acc, 2))
		else $error("interrupt rose without cause");
	chk_irq_fall: assert property ($fell(window_irq) |-> $past(wr_acc) || $past(wr_acc, 2))
		else $error("interrupt fell without write");

endmodule : awc_adc_window_compare_chk

bind awc_adc_window_compare awc_adc_window_compare_chk #(.ADDR_W(ADDR_W)) chk_inst (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.conv_done(conv_done),
	.conv_start(conv_start),
	.converter_enable(converter_enable),
	.burst_mode_enable(burst_mode_enable),
	.left_justify_select(left_justify_select),
	.track_mode_select(track_mode_select),
	.post_track_time_select(post_track_time_select),
	.burst_powerup_time(burst_powerup_time),
	.window_irq(window_irq)
);

// ### test/awc_adc_window_compare_tb_top.sv
/*
 * Self-checking bench for the window-compare block over its register bus.
 * Assumes the checker is bound by its own file; single 200 MHz clock.
 */
`timescale 1ns/1ps
module awc_adc_window_compare_tb_top
	import awc_pkg::*;
;
	logic pclk;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic conv_done = 1'b0;
	logic [11:0] conv_data = 12'h000;
	logic timer2_overflow = 1'b0;
	logic timer3_overflow = 1'b0;
	logic ext_convert_strobe = 1'b0;
	logic conv_start;
	logic converter_enable;
	logic burst_mode_enable;
	logic left_justify_select;
	logic [1:0] track_mode_select;
	logic [1:0] post_track_time_select;
	logic [3:0] burst_powerup_time;
	logic window_irq;
	int bad_count = 0;
	int n_tests = 0;
	int starts = 0;
	int s0;
	logic [31:0] rd;
	logic er;
	logic [15:0] gt;
	logic [15:0] lt;
	logic [7:0] pat;
	logic [11:0] vals [8] = '{12'h000, 12'h0ff, 12'h100, 12'h101, 12'h1ff, 12'h200, 12'h201, 12'hfff};

	awc_adc_window_compare #(.ADDR_W(12)) awc_adc_window_compare_inst (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.conv_done(conv_done),
		.conv_data(conv_data),
		.timer2_overflow(timer2_overflow),
		.timer3_overflow(timer3_overflow),
		.ext_convert_strobe(ext_convert_strobe),
		.conv_start(conv_start),
		.converter_enable(converter_enable),
		.burst_mode_enable(burst_mode_enable),
		.left_justify_select(left_justify_select),
		.track_mode_select(track_mode_select),
		.post_track_time_select(post_track_time_select),
		.burst_powerup_time(burst_powerup_time),
		.window_irq(window_irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock and start-pulse counter; counting avoids racing one-cycle pulses
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (conv_start === 1'b1) starts <= starts + 1;
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// One bus transfer; request held until pready is seen at a rising edge
	task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", pready, 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task conv(input logic [11:0] d);
		conv_done <= 1'b1;
		conv_data <= d;
		@(posedge pclk);
		conv_done <= 1'b0;
		@(posedge pclk);
	endtask : conv

	// Clear flags, convert, then compare flag and enabled interrupt line
	task wcase(input logic lj, input logic [11:0] d, input logic e);
		apb(1'b1, AWC_IDX_CTRL, {5'h0, lj, 2'h0});
		apb(1'b1, AWC_IDX_INT_CLR, 8'h03);
		conv(d);
		apb(1'b0, AWC_IDX_CTRL, 8'h00);
		chk("window_flag", rd[AWC_CN_WINDOW], e);
		chk("done_flag", rd[AWC_CN_DONE], 1'b1);
		chk("ljust_out", left_justify_select, lj);
		chk("window_irq", window_irq, e);
	endtask : wcase

	task final_report;
		if (bad_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		final_report;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("track_mode_select", track_mode_select, 2'h3);
		chk("post_track_rst", post_track_time_select, 2'h3);
		apb(1'b0, AWC_IDX_TRACK, 8'h00);
		chk("track_reg", rd, 32'hff);
		apb(1'b0, AWC_IDX_GT_L, 8'h00);
		chk("gt_low", rd, 32'hff);
		apb(1'b0, AWC_IDX_LT_H, 8'h00);
		chk("lt_high", rd, 32'h0);
		apb(1'b0, 10'h001, 8'h00);
		chk("unmapped_err", er, 1'b1);
		chk("unmapped_data", rd, 32'h0);
		for (int t = 0; t < 4; t++) begin
			apb(1'b1, AWC_IDX_TRACK, {4'h5, t[1:0], 2'h2});
			apb(1'b0, AWC_IDX_TRACK, 8'h00);
			chk("track_rw", rd, {24'h0, 4'h5, t[1:0], 2'h2});
			chk("track_mode_select", track_mode_select, t[1:0]);
			chk("post_track", post_track_time_select, 2'h2);
			chk("powerup", burst_powerup_time, 4'h5);
		end
		// outside then inside, bounds and full scale
		apb(1'b1, AWC_IDX_INT_EN, 8'h01);
		for (int m = 0; m < 2; m++) begin
			gt = m ? 16'h0100 : 16'h0200;
			lt = m ? 16'h0200 : 16'h0100;
			pat = m ? 8'h18 : 8'hc3;
			apb(1'b1, AWC_IDX_GT_H, gt[15:8]);
			apb(1'b1, AWC_IDX_GT_L, gt[7:0]);
			apb(1'b1, AWC_IDX_LT_H, lt[15:8]);
			apb(1'b1, AWC_IDX_LT_L, lt[7:0]);
			for (int i = 0; i < 8; i++) wcase(1'b0, vals[i], pat[i]);
		end
		// left-justified words against the same limits
		wcase(1'b1, 12'h010, 1'b0);
		wcase(1'b1, 12'h021, 1'b0);
		wcase(1'b1, 12'h018, 1'b1);
		apb(1'b0, AWC_IDX_RES_H, 8'h00);
		chk("result_high", rd, 32'h01);
		apb(1'b0, AWC_IDX_RES_L, 8'h00);
		chk("result_low", rd, 32'h80);
		// mask, unmask and clear the sticky match
		apb(1'b1, AWC_IDX_INT_EN, 8'h00);
		apb(1'b0, AWC_IDX_INT_STAT, 8'h00);
		chk("status_kept", rd[AWC_INT_WINDOW], 1'b1);
		chk("status_done", rd[AWC_INT_DONE], 1'b1);
		chk("irq_masked", window_irq, 1'b0);
		apb(1'b1, AWC_IDX_INT_EN, 8'h01);
		apb(1'b0, AWC_IDX_INT_STAT, 8'h00);
		chk("irq_unmasked", window_irq, 1'b1);
		apb(1'b1, AWC_IDX_INT_CLR, 8'h01);
		apb(1'b0, AWC_IDX_INT_STAT, 8'h00);
		chk("status_clear", rd[AWC_INT_WINDOW], 1'b0);
		chk("irq_cleared", window_irq, 1'b0);
		// every start source, then a disabled start
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, AWC_IDX_CTRL, 8'h80 | s[7:0]);
			chk("enable_out", converter_enable, 1'b1);
			s0 = starts;
			case (s)
				0: apb(1'b1, AWC_IDX_CTRL, 8'h90);
				1: timer3_overflow <= 1'b1;
				2: ext_convert_strobe <= 1'b1;
				default: timer2_overflow <= 1'b1;
			endcase
			@(posedge pclk);
			timer3_overflow <= 1'b0;
			timer2_overflow <= 1'b0;
			repeat (8) @(posedge pclk);
			ext_convert_strobe <= 1'b0;
			chk("start_count", starts - s0, 1);
			apb(1'b0, AWC_IDX_CTRL, 8'h00);
			chk("busy_set", rd[AWC_CN_BUSY], 1'b1);
			conv(12'h000);
		end
		apb(1'b1, AWC_IDX_CTRL, 8'h43);
		chk("burst_out", burst_mode_enable, 1'b1);
		chk("enable_off", converter_enable, 1'b0);
		s0 = starts;
		timer2_overflow <= 1'b1;
		@(posedge pclk);
		timer2_overflow <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("start_disabled", starts - s0, 0);
		final_report;
	end

endmodule : awc_adc_window_compare_tb_top
